// file: rtl/cmcs_pkg.sv
// constants and carrier types for the can mode control and status block
package cmcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS   = 1000;
  localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_FILT_NS  = 300;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BIT_LAST  = 4'(BIT_CYC - 1);
  localparam logic [3:0] WAKE_LAST = 4'(WAKE_FILT_CYC - 1);
  localparam logic [3:0] IDLE_BITS = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // register indexes
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_VEC   = 3'h2;
  localparam logic [2:0] ADDR_FCTRL = 3'h3;
  localparam logic [2:0] ADDR_FIFO  = 3'h4;
  localparam logic [2:0] ADDR_TIM2  = 3'h5;
  localparam logic [2:0] ADDR_TXST  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // mode codes
  localparam logic [2:0] MODE_NORM = 3'h0;
  localparam logic [2:0] MODE_DIS  = 3'h1;
  localparam logic [2:0] MODE_LOOP = 3'h2;
  localparam logic [2:0] MODE_LSTN = 3'h3;
  localparam logic [2:0] MODE_CFG  = 3'h4;
  localparam logic [2:0] MODE_RSV5 = 3'h5;
  localparam logic [2:0] MODE_RSV6 = 3'h6;
  localparam logic [2:0] MODE_LALL = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int C1_IDLE_STOP = 13;
  localparam int C1_ABORT     = 12;
  localparam int C1_REQ_LSB   = 8;
  localparam int C1_CAP       = 3;
  localparam int C1_WIN       = 0;
  localparam int FC_BC_LSB    = 13;
  localparam int TIM2_WAKFILT = 14;
  localparam int TX_REQ       = 0;
  localparam int TX_ABT       = 1;
  localparam int TX_WAKE      = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic [2:0]  REQ_RST   = MODE_CFG;
  localparam logic [15:0] TIM2_RST  = 16'h0000;
  localparam logic [15:0] TIM2_MASK = 16'h47ff;
  localparam logic        RX_RST    = 1'b1;
  localparam logic [4:0]  DNFL_MAX  = 5'h11;
  localparam logic [6:0]  IC_NONE   = 7'h40;
  localparam logic [6:0]  IC_ERR    = 7'h41;
  localparam logic [6:0]  IC_WAKE   = 7'h42;
  localparam logic [6:0]  IC_OVF    = 7'h43;
  localparam logic [6:0]  IC_FIFO   = 7'h44;
  localparam logic [5:0]  BUF_CNT_TAB [0:7] = '{6'h04, 6'h06, 6'h08, 6'h0c,
                                                6'h10, 6'h18, 6'h20, 6'h00};

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        tx_busy;
    logic        tx_done;
    logic        rx_done;
    logic        err_irq;
    logic        ovf_irq;
    logic        fifo_irq;
    logic [15:0] buf_irq;
    logic [3:0]  filt_hit;
    logic [4:0]  fifo_wr;
    logic [4:0]  fifo_rd;
  } cmcs_eng_stat_t;

  typedef struct packed {
    logic       rx;
    logic       rx_en;
    logic       tx_en;
    logic       tx_start;
    logic       passive;
    logic       accept_all;
    logic       err_clr;
    logic       abort_all;
    logic       halted;
    logic       capture;
    logic       window_select_bit;
    logic [4:0] dn_len;
    logic [5:0] buf_count;
    logic [4:0] fifo_start;
  } cmcs_eng_ctl_t;

endpackage : cmcs_pkg

// file: rtl/cmcs_rx_idle.sv
// receive pin synchroniser, bit tick and bus idle detector
`timescale 1ns/1ps
`default_nettype none
module cmcs_rx_idle (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // bus side
  input  wire logic rx_pin,
  input  wire logic restart,
  // status
  output logic      rx_level,
  output logic      bus_idle
);

  logic       s1_ff;
  logic       s2_ff;
  logic       s3_ff;
  logic       lvl_ff;
  logic [3:0] div_ff;
  logic [3:0] idle_ff;
  wire        tick  = (div_ff == cmcs_pkg::BIT_LAST);
  wire        agree = (s2_ff == s3_ff);
  wire        full  = (idle_ff == cmcs_pkg::IDLE_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // three stage sync, level moves when stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff  <= cmcs_pkg::RX_RST;
      s2_ff  <= cmcs_pkg::RX_RST;
      s3_ff  <= cmcs_pkg::RX_RST;
      lvl_ff <= cmcs_pkg::RX_RST;
    end else begin
      s1_ff  <= rx_pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= agree ? s3_ff : lvl_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit rate divider and recessive bit count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_ff  <= 4'h0;
      idle_ff <= 4'h0;
    end else begin
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      if (restart || !lvl_ff) begin
        idle_ff <= 4'h0;
      end else if (tick && !full) begin
        idle_ff <= idle_ff + 4'h1;
      end
    end
  end

  assign rx_level = lvl_ff;
  assign bus_idle = full;

endmodule : cmcs_rx_idle
`default_nettype wire

// file: rtl/cmcs_mode_ctrl.sv
// can mode controller with control and status registers
//
// Behaviour
// (RULE1) mode and reported mode change only after 11 recessive bits of idle bus
// (RULE2) configuration mode: no transmit or receive, error counters cleared, flags kept
// (RULE3) locked registers writable only in configuration mode
// (RULE4) configuration entry waits until the running transmission ends
// (RULE5) disable mode: no traffic, flags and counters kept, wake flag may set
// (RULE6) disable request waits for idle bus, reports 001, pins go to port use
// (RULE7) wake filter bit low-pass filters the receive input during sleep
// (RULE8) transmit waits 11 bits after mode entry; disable in that wait aborts it
// (RULE9) normal mode owns both pins and moves frames through them
// (RULE10) listen-only: transmit pin to port use, no acknowledge, counters idle; code keeps pins_to_can high and only drops bus_transmit_oe
// (RULE11) listen-all mode ignores errors and accepts every message
// (RULE12) loopback routes internal transmit to internal receive, pins to port use
// (RULE13) request and report fields share one 3-bit mode encoding
// (RULE14) abort-all aborts every buffer and clears itself when all are aborted
// (RULE15) idle-stop bit halts the block while the system idles
// (RULE16) capture enable makes a timestamp event per received message
// (RULE17) window select picks filter window at 1, buffer window at 0
// (RULE18) data-byte filter length 0 to 17 compares bits, above is invalid
// (RULE19) matched filter number 0 to 15 reported read-only
// (RULE20) interrupt code gives none, error, wake, overflow, fifo or buffer number
// (RULE21) buffer count field maps 000 to 110 onto 4 to 32 buffers
// (RULE22) fifo start buffer field plus read-only write and next-read pointers
// (RULE23) locked writes outside configuration mode leave contents unchanged
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cmcs_mode_ctrl (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  // register port
  input  wire logic [2:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [15:0]                  reg_rdata,
  // system state
  input  wire logic                    sys_idle,
  input  wire logic                    sys_sleep,
  // bus pins
  input  wire logic                    bus_receive_pin,
  output logic                         bus_transmit_pin,
  output logic                         bus_transmit_oe,
  output logic                         pins_to_can,
  // protocol engine
  input  wire logic                    eng_tx,
  input  wire cmcs_pkg::cmcs_eng_stat_t eng_stat,
  output cmcs_pkg::cmcs_eng_ctl_t      eng_ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [2:0]              req_ff;
  logic [2:0]              mode_ff;
  logic                    idle_stop_ff;
  logic                    abort_ff;
  logic                    cap_ff;
  logic                    win_ff;
  logic [4:0]              dn_ff;
  logic [2:0]              bc_ff;
  logic [4:0]              fsa_ff;
  logic [15:0]             tim2_ff;
  logic                    transmit_request_flag_ff;
  logic                    abt_ff;
  logic                    wake_ff;
  logic                    tx_wait_ff;
  logic                    rx_prev_ff;
  logic [3:0]              wk_cnt_ff;
  logic [15:0]             rdata_ff;
  logic                    txp_ff;
  logic                    txoe_ff;
  logic                    pins_ff;
  cmcs_pkg::cmcs_eng_ctl_t ctl_ff;
  logic                    rx_level;
  logic                    bus_idle;

  ////////////////////////////////////////////////////////////////////////////
  // idle detector
  wire accept;

  cmcs_rx_idle u_rx_idle (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .rx_pin   (bus_receive_pin),
    .restart  (accept),
    .rx_level (rx_level),
    .bus_idle (bus_idle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire cfg      = (mode_ff == cmcs_pkg::MODE_CFG);
  wire wr_ctrl1 = reg_wr && (reg_addr == cmcs_pkg::ADDR_CTRL1);
  wire wr_ctrl2 = reg_wr && (reg_addr == cmcs_pkg::ADDR_CTRL2) && cfg; // RULE3
  wire wr_fctrl = reg_wr && (reg_addr == cmcs_pkg::ADDR_FCTRL) && cfg; // RULE3
  wire wr_tim2  = reg_wr && (reg_addr == cmcs_pkg::ADDR_TIM2) && cfg; // RULE3
  wire wr_txst  = reg_wr && (reg_addr == cmcs_pkg::ADDR_TXST);
  wire halted   = idle_stop_ff && sys_idle; // RULE15
  wire tx_busy  = eng_stat.tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // mode change
  wire req_rsv  = (req_ff == cmcs_pkg::MODE_RSV5) || (req_ff == cmcs_pkg::MODE_RSV6); // RULE13
  wire cfg_hold = (req_ff == cmcs_pkg::MODE_CFG) && tx_busy; // RULE4
  assign accept = (req_ff != mode_ff) && !req_rsv && bus_idle && !cfg_hold && !halted; // RULE1
  wire [2:0] nxt_mode = accept ? req_ff : mode_ff; // RULE6
  wire to_tx    = (req_ff == cmcs_pkg::MODE_NORM) || (req_ff == cmcs_pkg::MODE_LOOP);
  wire to_dis   = accept && (req_ff == cmcs_pkg::MODE_DIS);

  ////////////////////////////////////////////////////////////////////////////
  // per-mode enables
  wire m_norm   = (mode_ff == cmcs_pkg::MODE_NORM);
  wire m_loop   = (mode_ff == cmcs_pkg::MODE_LOOP);
  wire m_lstn   = (mode_ff == cmcs_pkg::MODE_LSTN);
  wire m_lall   = (mode_ff == cmcs_pkg::MODE_LALL);
  wire m_dis    = (mode_ff == cmcs_pkg::MODE_DIS);
  wire rx_en    = (m_norm || m_loop || m_lstn || m_lall) && !halted; // RULE2 RULE5
  wire tx_en    = (m_norm || m_loop) && !halted; // RULE10 RULE2
  wire tx_start = tx_en && transmit_request_flag_ff && !tx_wait_ff && !abort_ff; // RULE8

  ////////////////////////////////////////////////////////////////////////////
  // transmit request, abort and abort-all
  wire nxt_tx_wait = (accept && to_tx) || (tx_wait_ff && !bus_idle && !to_dis); // RULE8
  wire dis_abort   = to_dis && tx_wait_ff && transmit_request_flag_ff; // RULE8
  wire all_abort   = abort_ff && !tx_busy && transmit_request_flag_ff; // RULE14
  wire set_req     = wr_txst && reg_wdata[cmcs_pkg::TX_REQ];
  wire clr_req     = eng_stat.tx_done || dis_abort || all_abort;
  wire nxt_transmit_request_flag   = set_req || (transmit_request_flag_ff && !clr_req);
  wire clr_abt     = wr_txst && reg_wdata[cmcs_pkg::TX_ABT];
  wire nxt_abt     = dis_abort || all_abort || (abt_ff && !clr_abt);
  wire abort_done  = !transmit_request_flag_ff && !tx_busy; // RULE14
  wire set_abort   = wr_ctrl1 && reg_wdata[cmcs_pkg::C1_ABORT];
  wire nxt_abort   = set_abort || (abort_ff && !abort_done); // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // wake detection
  wire dom       = !rx_level;
  wire rx_fall   = rx_prev_ff && dom;
  wire filt_on   = tim2_ff[cmcs_pkg::TIM2_WAKFILT] && sys_sleep; // RULE7
  wire filt_hit  = dom && (wk_cnt_ff == cmcs_pkg::WAKE_LAST);
  wire wake_hit  = m_dis && (filt_on ? filt_hit : rx_fall); // RULE5 RULE7
  wire [3:0] nxt_wk_cnt = !dom ? 4'h0 :
                          (wk_cnt_ff == cmcs_pkg::WAKE_LAST) ? wk_cnt_ff :
                          wk_cnt_ff + 4'h1;
  wire clr_wake  = wr_txst && reg_wdata[cmcs_pkg::TX_WAKE];
  wire nxt_wake  = wake_hit || (wake_ff && !clr_wake);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt code
  function automatic logic [6:0] buf_code(input logic [15:0] f);
    logic [6:0] r;
    r = cmcs_pkg::IC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (f[i]) begin
        r = 7'(i);
      end
    end
    return r;
  endfunction : buf_code

  wire [6:0] icode = eng_stat.err_irq  ? cmcs_pkg::IC_ERR  :
                     wake_ff           ? cmcs_pkg::IC_WAKE :
                     eng_stat.ovf_irq  ? cmcs_pkg::IC_OVF  :
                     eng_stat.fifo_irq ? cmcs_pkg::IC_FIFO :
                     buf_code(eng_stat.buf_irq); // RULE20

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [15:0] rd_ctrl1 = {2'h0, idle_stop_ff, abort_ff, 1'b0, req_ff, mode_ff,
                          1'b0, cap_ff, 2'h0, win_ff}; // RULE13
  wire [15:0] rd_ctrl2 = {11'h000, dn_ff};
  wire [15:0] rd_vec   = {3'h0, 1'b0, eng_stat.filt_hit, 1'b0, icode}; // RULE19
  wire [15:0] rd_fctrl = {bc_ff, 8'h00, fsa_ff};
  wire [15:0] rd_fifo  = {3'h0, eng_stat.fifo_wr, 3'h0, eng_stat.fifo_rd}; // RULE22
  wire [15:0] rd_txst  = {13'h0000, wake_ff, abt_ff, transmit_request_flag_ff};
  wire [15:0] rd_mux   = (reg_addr == cmcs_pkg::ADDR_CTRL1) ? rd_ctrl1 :
                         (reg_addr == cmcs_pkg::ADDR_CTRL2) ? rd_ctrl2 :
                         (reg_addr == cmcs_pkg::ADDR_VEC)   ? rd_vec   :
                         (reg_addr == cmcs_pkg::ADDR_FCTRL) ? rd_fctrl :
                         (reg_addr == cmcs_pkg::ADDR_FIFO)  ? rd_fifo  :
                         (reg_addr == cmcs_pkg::ADDR_TIM2)  ? tim2_ff  :
                         (reg_addr == cmcs_pkg::ADDR_TXST)  ? rd_txst  :
                         16'h0000;
  wire [15:0] nxt_rdata = reg_rd ? rd_mux : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // engine controls
  wire dn_ok = (dn_ff <= cmcs_pkg::DNFL_MAX);
  cmcs_pkg::cmcs_eng_ctl_t nxt_ctl;
  always_comb begin
    nxt_ctl            = '0;
    nxt_ctl.rx         = m_loop ? eng_tx : rx_level; // RULE12
    nxt_ctl.rx_en      = rx_en;
    nxt_ctl.tx_en      = tx_en;
    nxt_ctl.tx_start   = tx_start; // RULE8
    nxt_ctl.passive    = m_lstn; // RULE10
    nxt_ctl.accept_all = m_lall; // RULE11
    nxt_ctl.err_clr    = cfg; // RULE2
    nxt_ctl.abort_all  = abort_ff; // RULE14
    nxt_ctl.halted     = halted; // RULE15
    nxt_ctl.capture    = eng_stat.rx_done && cap_ff && rx_en; // RULE16
    nxt_ctl.window_select_bit        = win_ff; // RULE17
    nxt_ctl.dn_len     = dn_ok ? dn_ff : 5'h00; // RULE18
    nxt_ctl.buf_count  = cmcs_pkg::BUF_CNT_TAB[bc_ff]; // RULE21
    nxt_ctl.fifo_start = fsa_ff; // RULE22
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins
  wire nxt_txp  = m_norm ? eng_tx : 1'b1; // RULE9
  wire nxt_txoe = m_norm && !halted; // RULE10 RULE12 RULE6
  wire nxt_pins = m_norm || m_lstn || m_lall; // RULE9 RULE6 RULE12

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_ff       <= cmcs_pkg::REQ_RST;
      mode_ff      <= cmcs_pkg::MODE_CFG;
      idle_stop_ff <= 1'b0;
      cap_ff       <= 1'b0;
      win_ff       <= 1'b0;
      abort_ff     <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode; // RULE1
      abort_ff <= nxt_abort;
      if (wr_ctrl1) begin
        req_ff <= reg_wdata[cmcs_pkg::C1_REQ_LSB +: 3];
        win_ff <= reg_wdata[cmcs_pkg::C1_WIN];
      end
      if (wr_ctrl1 && cfg) begin // RULE3 RULE23
        idle_stop_ff <= reg_wdata[cmcs_pkg::C1_IDLE_STOP];
        cap_ff       <= reg_wdata[cmcs_pkg::C1_CAP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dn_ff   <= 5'h00;
      bc_ff   <= 3'h0;
      fsa_ff  <= 5'h00;
      tim2_ff <= cmcs_pkg::TIM2_RST;
    end else begin
      if (wr_ctrl2) begin // RULE23
        dn_ff <= reg_wdata[4:0];
      end
      if (wr_fctrl) begin // RULE23
        bc_ff  <= reg_wdata[cmcs_pkg::FC_BC_LSB +: 3];
        fsa_ff <= reg_wdata[4:0];
      end
      if (wr_tim2) begin // RULE23
        tim2_ff <= reg_wdata & cmcs_pkg::TIM2_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and wake filter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_request_flag_ff   <= 1'b0;
      abt_ff     <= 1'b0;
      wake_ff    <= 1'b0;
      tx_wait_ff <= 1'b0;
      rx_prev_ff <= cmcs_pkg::RX_RST;
      wk_cnt_ff  <= 4'h0;
    end else begin
      transmit_request_flag_ff   <= nxt_transmit_request_flag;
      abt_ff     <= nxt_abt;
      wake_ff    <= nxt_wake;
      tx_wait_ff <= nxt_tx_wait;
      rx_prev_ff <= rx_level;
      wk_cnt_ff  <= nxt_wk_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
      txp_ff   <= 1'b1;
      txoe_ff  <= 1'b0;
      pins_ff  <= 1'b0;
      ctl_ff   <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
      txp_ff   <= nxt_txp;
      txoe_ff  <= nxt_txoe;
      pins_ff  <= nxt_pins;
      ctl_ff   <= nxt_ctl;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign bus_transmit_pin = txp_ff;
  assign bus_transmit_oe  = txoe_ff;
  assign pins_to_can      = pins_ff;
  assign eng_ctl          = ctl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_mode_on_idle: assert property ($changed(mode_ff) |-> $past(bus_idle)) // RULE1
    else $error("mode changed without idle bus");
  a_cfg_no_busy: assert property (
    ($changed(mode_ff) && cfg) |-> !$past(tx_busy)) // RULE4
    else $error("configuration entered during transmission");
  a_cfg_quiet: assert property ( // RULE2
    cfg |=> (ctl_ff.err_clr && !ctl_ff.tx_en && !ctl_ff.rx_en))
    else $error("configuration mode not quiet");
  a_lock_fctrl: assert property ( // RULE23
    (reg_wr && reg_addr == cmcs_pkg::ADDR_FCTRL && !cfg) |=> $stable(fsa_ff) && $stable(bc_ff))
    else $error("locked register written");
  a_dis_aborts: assert property (
    (tx_wait_ff && transmit_request_flag_ff && to_dis && !tx_busy) |=> (abt_ff && m_dis)) // RULE8
    else $error("disable in wait did not abort");
  a_loop_route: assert property ( // RULE12
    ($past(m_loop) && m_loop) |-> ctl_ff.rx == $past(eng_tx))
    else $error("loopback not routed");
  a_pin_port: assert property (!m_norm |=> !txoe_ff) // RULE10
    else $error("transmit pin driven outside normal mode");
  a_abort_clear: assert property (
    (abort_ff && !transmit_request_flag_ff && !tx_busy && !set_abort) |=> !abort_ff) // RULE14
    else $error("abort-all not cleared");
  a_cap_gate: assert property (!cap_ff |=> !ctl_ff.capture) // RULE16
    else $error("capture without enable");
  a_dn_range: assert property (ctl_ff.dn_len <= cmcs_pkg::DNFL_MAX) // RULE18
    else $error("data-byte length out of range");
  a_icode_none: assert property (
    (reg_rd && reg_addr == cmcs_pkg::ADDR_VEC && !wake_ff && !eng_stat.err_irq &&
     !eng_stat.ovf_irq && !eng_stat.fifo_irq && eng_stat.buf_irq == 16'h0000)
    |=> reg_rdata[6:0] == cmcs_pkg::IC_NONE) // RULE20
    else $error("no-interrupt code wrong");
  a_halt_freeze: assert property (halted |=> $stable(mode_ff)) // RULE15
    else $error("mode moved while halted");

  c_to_normal: cover property ($changed(mode_ff) && m_norm);
  c_to_disable: cover property ($changed(mode_ff) && m_dis);
  c_wait_abort: cover property (dis_abort);
  c_wake_set: cover property ($rose(wake_ff));

endmodule : cmcs_mode_ctrl
`default_nettype wire

// file: sim/cmcs_bus_node.sv
// model of the other nodes on the bus: idle recessive or bit-wide traffic
`timescale 1ns/1ps
`default_nettype none
module cmcs_bus_node (
  // clock
  input  wire logic sys_clk,
  // control and pins
  input  wire logic traffic,
  input  wire logic tx_pin,
  input  wire logic tx_oe,
  output logic      rx_line
);
  logic [4:0] cnt_ff = 5'h00;
  always_ff @(posedge sys_clk) begin
    cnt_ff <= (cnt_ff == 5'h13) ? 5'h00 : cnt_ff + 5'h01;
  end
  // wired and: dominant wins, traffic never leaves 11 recessive bits
  assign rx_line = (tx_oe ? tx_pin : 1'b1) & ~(traffic & (cnt_ff < 5'h0a));
endmodule : cmcs_bus_node
`default_nettype wire

// file: sim/can_mode_control_and_status_bench.sv
// self-checking bench for the mode controller
`timescale 1ns/1ps
`default_nettype none
module can_mode_control_and_status_bench;
  logic                     sys_clk, resetn, reg_wr, reg_rd, traffic, rx_line;
  logic                     idle, sleep, etx;
  logic [2:0]               reg_addr;
  logic [15:0]              reg_wdata, reg_rdata, d;
  logic                     tx_pin, tx_oe, pins_to_can;
  cmcs_pkg::cmcs_eng_stat_t stat;
  cmcs_pkg::cmcs_eng_ctl_t  ctl;
  int                       err_total, check_count, cyc;
  logic [2:0]               mtab [0:3] = '{3'h3, 3'h2, 3'h7, 3'h1};
  logic                     ptab [0:3] = '{1'b1, 1'b0, 1'b1, 1'b0};

  cmcs_mode_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sys_idle(idle), .sys_sleep(sleep), .bus_receive_pin(rx_line),
    .bus_transmit_pin(tx_pin), .bus_transmit_oe(tx_oe), .pins_to_can(pins_to_can),
    .eng_tx(etx), .eng_stat(stat), .eng_ctl(ctl));
  cmcs_bus_node node (.sys_clk(sys_clk), .traffic(traffic), .tx_pin(tx_pin),
    .tx_oe(tx_oe), .rx_line(rx_line));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count = check_count + 1;
    if (e !== g) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask : rd
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 150; i++) begin
      rd(3'h0, d);
      if (d[7:5] === m) break;
    end
    chk("mode", {13'h0000, m}, {13'h0000, d[7:5]});
  endtask : wait_mode
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd, traffic, idle, sleep, err_total, check_count, cyc} = '0;
    etx       = 1'b1;
    reg_addr  = 3'h0;
    reg_wdata = 16'h0000;
    stat      = '0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(3'h0, d); chk("ctrl1", 16'h0480, d);
    rd(3'h7, d); chk("unmapped", 16'h0000, d);
    rd(3'h2, d); chk("vec", 16'h0040, d);
    stat.filt_hit <= 4'h5;
    stat.buf_irq  <= 16'h0008;
    stat.err_irq  <= 1'b1;
    rd(3'h2, d); chk("vec", 16'h0541, d);
    stat.err_irq  <= 1'b0;
    rd(3'h2, d); chk("vec", 16'h0503, d);
    wr(3'h0, 16'h2408);
    wr(3'h3, 16'hc005);
    rd(3'h0, d); chk("ctrl1", 16'h2488, d);
    rd(3'h3, d); chk("fctrl", 16'hc005, d);
    chk("buf_count", 16'h0020, {10'h000, ctl.buf_count});
    wr(3'h5, 16'hffff);
    rd(3'h5, d); chk("tim2", 16'h47ff, d);
    traffic <= 1'b1;
    wr(3'h0, 16'h2008);
    repeat (200) @(posedge sys_clk);
    rd(3'h0, d); chk("ctrl1", 16'h2088, d);
    traffic <= 1'b0;
    wait_mode(3'h0);
    chk("oe", 16'h0001, {15'h0000, tx_oe});
    wr(3'h3, 16'h0000);
    rd(3'h3, d); chk("fctrl", 16'hc005, d);
    for (int k = 0; k < 4; k++) begin
      wr(3'h0, 16'h2008 | {5'h00, mtab[k], 8'h00});
      wait_mode(mtab[k]);
      chk("pins", {15'h0000, ptab[k]}, {15'h0000, pins_to_can});
      chk("oe", 16'h0000, {15'h0000, tx_oe});
    end
    sleep   <= 1'b1;
    traffic <= 1'b1;
    repeat (30) @(posedge sys_clk);
    traffic <= 1'b0;
    rd(3'h6, d); chk("wake", 16'h0004, d & 16'h0004);
    wr(3'h0, 16'h2508);
    repeat (150) @(posedge sys_clk);
    rd(3'h0, d); chk("ctrl1", 16'h2528, d);
    stat.tx_busy <= 1'b1;
    wr(3'h0, 16'h2408);
    repeat (150) @(posedge sys_clk);
    rd(3'h0, d); chk("ctrl1", 16'h2428, d);
    stat.tx_busy <= 1'b0;
    wait_mode(3'h4);
    chk("err_clr", 16'h0001, {15'h0000, ctl.err_clr});
    wr(3'h1, 16'h0011);
    rd(3'h1, d); chk("ctrl2", 16'h0011, d);
    chk("dn_len", 16'h0011, {11'h000, ctl.dn_len});
    wr(3'h1, 16'h0012);
    rd(3'h1, d); chk("dn_len", 16'h0000, {11'h000, ctl.dn_len});
    wr(3'h6, 16'h0001);
    wr(3'h0, 16'h3401);
    rd(3'h6, d); chk("txst", 16'h0006, d);
    rd(3'h0, d); chk("ctrl1", 16'h2481, d);
    chk("win", 16'h0001, {15'h0000, ctl.window_select_bit});
    wr(3'h6, 16'h0006);
    rd(3'h6, d); chk("txst", 16'h0000, d);
    idle <= 1'b1;
    wr(3'h0, 16'h2200);
    repeat (150) @(posedge sys_clk);
    rd(3'h0, d); chk("ctrl1", 16'h2280, d);
    chk("halted", 16'h0001, {15'h0000, ctl.halted});
    idle <= 1'b0;
    wait_mode(3'h2);
    etx <= 1'b0;
    rd(3'h0, d); chk("loop_rx", 16'h0000, {15'h0000, ctl.rx});
    chk("txp", 16'h0001, {15'h0000, tx_pin});
    wrap_up();
  end
endmodule : can_mode_control_and_status_bench
`default_nettype wire
